//--- design/adcs_pkg.sv
// Constants, register map and carrier types of the dual sample-and-hold ADC sequencer.
// Assumes one 25 MHz system clock; the ADC clock is an enable pulse derived from it.
`default_nettype none
package adcs_pkg;
  localparam int SLOTS = 16;
  localparam int NIRQ = 9;
  localparam int DW = 12;
  localparam int AW = 8;
  localparam int SYS_PERIOD_NS = 40;
  localparam int ADC_DIV = 2;
  localparam int ADC_PERIOD_NS = SYS_PERIOD_NS * ADC_DIV;
  localparam int CONV_CYCLES = 13;
  localparam logic [3:0] RR_RESET = 4'hF;
  localparam logic [AW-1:0] OFS_SLOT0 = 8'h00;
  localparam logic [AW-1:0] OFS_MODE = 8'h40;
  localparam logic [AW-1:0] OFS_INTSEL0 = 8'h44;
  localparam logic [AW-1:0] OFS_RTRIG_LO = 8'h58;
  localparam logic [AW-1:0] OFS_RTRIG_HI = 8'h5C;
  localparam logic [AW-1:0] OFS_STATUS = 8'h60;
  localparam int ACQ_LSB = 0;
  localparam int ACQ_W = 6;
  localparam int CHANNEL_SELECT_LSB = 6;
  localparam int TRIG_LSB = 11;
  localparam int INT_SEL_LSB = 0;
  localparam int INT_EN_BIT = 5;
  localparam int INT_CONT_BIT = 6;
  localparam int INT_HALF = 8;
  localparam logic [4:0] TRIG_MIN = 5'h05;
  localparam logic [4:0] TRIG_MAX = 5'h14;
  localparam logic [4:0] SRC_MAX = 5'h0F;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [AW-1:0] paddr;
    logic [31:0] pwdata;
  } adcs_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } adcs_apb_rsp_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMP = 3'b010,
    ST_CONV = 3'b100
  } adcs_state_t;
endpackage
`default_nettype wire

//--- design/adcs_rr_arbiter.sv
// Round-robin picker over the sixteen pending slot flags.
// Assumes the pointer names the slot converted last.
`timescale 1ns/1ns
`default_nettype none
module adcs_rr_arbiter import adcs_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [SLOTS-1:0] pend,
  input wire logic [3:0] ptr,
  output logic [3:0] grantIdx,
  output logic grantVld
);
  // [RQ17] Search from pointer plus one.
  always_comb begin
    logic [3:0] idx;
    idx = 4'h0;
    grantIdx = 4'h0;
    grantVld = 1'b0;
    for (int i = SLOTS; i >= 1; i--) begin
      idx = 4'(32'(ptr) + i);
      if (pend[idx]) begin
        grantIdx = idx;
        grantVld = 1'b1;
      end
    end
  end

  logic [3:0] gap;
  assign gap = 4'(grantIdx - ptr - 4'h1);

  // Pending flags rotated so that bit zero is the slot after the pointer.
  logic [31:0] rotPend;
  logic [15:0] nearMask;
  assign rotPend = {pend, pend} >> (5'(ptr) + 5'h01);
  assign nearMask = (16'h0001 << gap) - 16'h0001;

  rr_pick_pending_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ17]
    (pend != 16'h0000) |-> grantVld && pend[grantIdx] && ((rotPend[15:0] & nearMask) == 16'h0000))
    else $error("Arbiter skipped a nearer pending slot.");
endmodule // adcs_rr_arbiter
`default_nettype wire

//--- design/adcs_seq_top.sv
// Sixteen-slot ADC sequencer: dual sample-and-hold, end-of-conversion and nine interrupts.
// Assumes an APB master, synchronous trigger pulses and digitised analog inputs.
// How it works
// [RQ1] Two sample-and-hold paths, each with its own channel multiplexer.
// [RQ2] Sampled value is the mean of window start and end inputs.
// [RQ3] Single mode drives just one of the two sample paths.
// [RQ4] Simultaneous mode samples both together, converts upper path first.
// [RQ5] One bit per even/odd slot pair selects single or simultaneous.
// [RQ6] Window length and channel always come from the triggered slot.
// [RQ7] End-of-conversion pulse lasts exactly one ADC clock.
// [RQ8] End-of-conversion comes one ADC clock before the result latch.
// [RQ9] Interrupt pulse trails its end-of-conversion by one ADC clock.
// [RQ10] Nine interrupt outputs, one bit each of a single port.
// [RQ11] Per-interrupt enable bit gates generation.
// [RQ12] Source field picks slot 0 to 15; larger codes never fire.
// [RQ13] Tenth interrupt fields in the fifth pair register do nothing.
// [RQ14] Each pair register holds two configs: upper byte and lower byte.
// [RQ15] Two-bit field per slot retriggers it from interrupt one or two.
// [RQ16] A nonzero retrigger field overrides the slot's trigger source.
// [RQ17] Pending slots served round robin from the slot after the last.
// [RQ18] After reset the last-served pointer holds slot 15.
// [RQ19] Conversion takes 13 ADC clocks after the sample window.
// [RQ20] Software must set the pulse position bit; only late pulses exist.
// [RQ21] Simultaneous pair results go to each own slot with its own pulse.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module adcs_seq_top import adcs_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire adcs_apb_req_t apbReq,
  output adcs_apb_rsp_t apbRsp,
  input wire logic [SLOTS-1:0] pwmTrig,
  input wire logic [7:0][DW-1:0] chanA,
  input wire logic [7:0][DW-1:0] chanB,
  output logic [SLOTS-1:0][DW-1:0] resultReg,
  output logic [SLOTS-1:0] eocOut,
  output logic [NIRQ-1:0] converterIrqOut
);
  logic [SLOTS-1:0][15:0] slotCfg_ff;
  logic [7:0] mode_ff;
  logic [4:0][15:0] intSel_ff;
  logic [1:0][15:0] rtrig_ff;
  adcs_apb_rsp_t rsp_ff;
  adcs_state_t state_ff;
  logic [3:0] slot_ff, convSlot_ff, ptr_ff;
  logic second_ff, simul_ff;
  logic [5:0] cnt_ff;
  logic [DW-1:0] startA_ff, startB_ff, heldA_ff, heldB_ff, convVal_ff;
  logic [SLOTS-1:0] eoc_ff, pend_ff, pwmPrev_ff;
  logic [NIRQ-1:0] irq_ff;
  logic [1:0] irqPrev_ff;
  logic [SLOTS-1:0][DW-1:0] result_ff;
  logic [1:0] divCnt_ff;

  // [RQ14] One byte per interrupt.
  function automatic logic [7:0] irqCfg(input logic [4:0][15:0] r, input int k);
    irqCfg = (k % 2 == 1) ? r[k / 2][15:INT_HALF] : r[k / 2][INT_HALF-1:0];
  endfunction

  function automatic logic [DW-1:0] mean(input logic [DW-1:0] a, input logic [DW-1:0] b);
    logic [DW:0] s;
    s = {1'b0, a} + {1'b0, b};
    mean = s[DW:1];
  endfunction

  // ADC clock enable.
  logic adcTick;
  assign adcTick = (divCnt_ff == 2'(ADC_DIV - 1));

  // APB decode.
  logic setup, wrEn, aSlot, aMode, aInt, aRtLo, aRtHi, aStat, hit;
  logic [3:0] wIdx;
  assign setup = apbReq.psel && !apbReq.penable;
  assign wrEn = apbReq.psel && apbReq.penable && rsp_ff.pready && apbReq.pwrite && !rsp_ff.pslverr;
  assign wIdx = apbReq.paddr[5:2];
  assign aSlot = (apbReq.paddr < OFS_MODE) && (apbReq.paddr[1:0] == 2'b00);
  assign aMode = (apbReq.paddr == OFS_MODE);
  assign aInt = (apbReq.paddr >= OFS_INTSEL0) && (apbReq.paddr < OFS_RTRIG_LO) && (apbReq.paddr[1:0] == 2'b00);
  assign aRtLo = (apbReq.paddr == OFS_RTRIG_LO);
  assign aRtHi = (apbReq.paddr == OFS_RTRIG_HI);
  assign aStat = (apbReq.paddr == OFS_STATUS);
  assign hit = aSlot || aMode || aInt || aRtLo || aRtHi || aStat;
  logic [2:0] iIdx;
  assign iIdx = 3'((apbReq.paddr - OFS_INTSEL0) >> 2);

  logic [31:0] rdData;
  always_comb begin
    rdData = 32'h0000_0000;
    if (aSlot) begin
      rdData = {16'h0000, slotCfg_ff[wIdx]};
    end else if (aMode) begin
      rdData = {24'h00_0000, mode_ff};
    end else if (aInt) begin
      rdData = {16'h0000, intSel_ff[iIdx]};
    end else if (aRtLo) begin
      rdData = {16'h0000, rtrig_ff[0]};
    end else if (aRtHi) begin
      rdData = {16'h0000, rtrig_ff[1]};
    end else if (aStat) begin
      rdData = {8'h00, state_ff != ST_IDLE ? 1'b1 : 1'b0, 3'h0, ptr_ff, pend_ff};
    end
  end

  // Current slot: the granted one while idle, else the one in progress.
  logic [3:0] grantIdx, curSlot, tgtSlot;
  logic grantVld;
  adcs_rr_arbiter uArb (
    .clk(clk),
    .rstn(rstn),
    .pend(pend_ff),
    .ptr(ptr_ff),
    .grantIdx(grantIdx),
    .grantVld(grantVld)
  );
  assign curSlot = (state_ff == ST_IDLE) ? grantIdx : slot_ff;
  assign tgtSlot = second_ff ? (slot_ff ^ 4'h1) : slot_ff;

  // [RQ6] Triggered slot config.
  logic [3:0] csel;
  logic [ACQ_W-1:0] acq;
  logic curSimul, capA, capB;
  assign csel = slotCfg_ff[curSlot][CHANNEL_SELECT_LSB+3:CHANNEL_SELECT_LSB];
  assign acq = slotCfg_ff[curSlot][ACQ_LSB+ACQ_W-1:ACQ_LSB];
  // [RQ5] Pair mode bit.
  assign curSimul = mode_ff[curSlot[3:1]];
  // [RQ3] One path in single mode.
  assign capA = curSimul || !csel[3];
  assign capB = curSimul || csel[3];

  // [RQ1] Two input multiplexers.
  logic [DW-1:0] inA, inB;
  assign inA = chanA[csel[2:0]];
  assign inB = chanB[csel[2:0]];

  // [RQ4] Upper path first, then lower.
  logic [DW-1:0] outVal;
  assign outVal = simul_ff ? (second_ff ? heldB_ff : heldA_ff) : (capB && !capA ? heldB_ff : heldA_ff);

  logic eocAny, inConv, eocSet, convEnd;
  assign eocAny = |eoc_ff;
  assign inConv = (state_ff == ST_CONV);
  // [RQ19] Thirteen ADC clocks.
  assign eocSet = adcTick && inConv && (cnt_ff == 6'(CONV_CYCLES - 2));
  assign convEnd = adcTick && inConv && (cnt_ff == 6'(CONV_CYCLES - 1));

  // Interrupt enables and sources.
  logic [NIRQ-1:0] irqHit;
  logic [NIRQ-1:0][4:0] irqSrc;
  always_comb begin
    logic [7:0] c;
    c = 8'h00;
    for (int k = 0; k < NIRQ; k++) begin
      c = irqCfg(intSel_ff, k);
      irqSrc[k] = c[INT_SEL_LSB+4:INT_SEL_LSB];
      // [RQ11] Enable gate.
      // [RQ12] Valid source only.
      irqHit[k] = c[INT_EN_BIT] && (irqSrc[k] <= SRC_MAX) && eoc_ff[irqSrc[k][3:0]];
    end
  end

  // Trigger sources.
  logic irq1Rise, irq2Rise;
  logic [SLOTS-1:0] pwmRise, trigHit, nxtPend;
  assign irq1Rise = irq_ff[0] && !irqPrev_ff[0];
  assign irq2Rise = irq_ff[1] && !irqPrev_ff[1];
  assign pwmRise = pwmTrig & ~pwmPrev_ff;
  always_comb begin
    logic [1:0] rt;
    logic [4:0] ts;
    rt = 2'b00;
    ts = 5'h00;
    for (int s = 0; s < SLOTS; s++) begin
      rt = rtrig_ff[s / 8][(s % 8) * 2 +: 2];
      ts = slotCfg_ff[s][TRIG_LSB+4:TRIG_LSB];
      // [RQ15] Retrigger decode.
      // [RQ16] Retrigger overrides source.
      if (rt != 2'b00) begin
        trigHit[s] = (rt == 2'b01) ? irq1Rise : ((rt == 2'b10) ? irq2Rise : 1'b0);
      end else begin
        trigHit[s] = (ts >= TRIG_MIN) && (ts <= TRIG_MAX) && pwmRise[4'(ts - TRIG_MIN)];
      end
    end
  end
  // A new trigger wins over the finishing clear.
  assign nxtPend = (pend_ff & ~(convEnd ? (16'h0001 << tgtSlot) : 16'h0000)) | trigHit;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      slotCfg_ff <= '0;
      mode_ff <= 8'h00;
      intSel_ff <= '0;
      rtrig_ff <= '0;
      rsp_ff <= '0;
    end else begin
      rsp_ff.pready <= setup;
      rsp_ff.pslverr <= setup && !hit;
      if (setup) begin
        rsp_ff.prdata <= rdData;
      end
      if (wrEn && aSlot) begin
        slotCfg_ff[wIdx] <= apbReq.pwdata[15:0];
      end else if (wrEn && aMode) begin
        mode_ff <= apbReq.pwdata[7:0];
      end else if (wrEn && aInt) begin
        intSel_ff[iIdx] <= apbReq.pwdata[15:0];
      end else if (wrEn && aRtLo) begin
        rtrig_ff[0] <= apbReq.pwdata[15:0];
      end else if (wrEn && aRtHi) begin
        rtrig_ff[1] <= apbReq.pwdata[15:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      divCnt_ff <= 2'b00;
      pend_ff <= '0;
      pwmPrev_ff <= '0;
      irqPrev_ff <= 2'b00;
      // [RQ18] Pointer at slot fifteen, so slot zero first.
      ptr_ff <= RR_RESET;
    end else begin
      divCnt_ff <= adcTick ? 2'b00 : 2'(divCnt_ff + 2'b01);
      pend_ff <= nxtPend;
      pwmPrev_ff <= pwmTrig;
      irqPrev_ff <= irq_ff[1:0];
      // [RQ17] Pointer follows each conversion.
      if (convEnd) begin
        ptr_ff <= tgtSlot;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      slot_ff <= 4'h0;
      second_ff <= 1'b0;
      simul_ff <= 1'b0;
      cnt_ff <= 6'h00;
      startA_ff <= '0;
      startB_ff <= '0;
      heldA_ff <= '0;
      heldB_ff <= '0;
    end else if (adcTick) begin
      case (state_ff)
        ST_IDLE: begin
          if (grantVld) begin
            slot_ff <= grantIdx;
            simul_ff <= curSimul;
            cnt_ff <= 6'(acq);
            if (capA) begin
              startA_ff <= inA;
            end
            if (capB) begin
              startB_ff <= inB;
            end
            state_ff <= ST_SAMP;
          end
        end
        ST_SAMP: begin
          if (cnt_ff == 6'h00) begin
            // [RQ2] Mean of both ends.
            if (capA) begin
              heldA_ff <= mean(startA_ff, inA);
            end
            if (capB) begin
              heldB_ff <= mean(startB_ff, inB);
            end
            state_ff <= ST_CONV;
          end else begin
            cnt_ff <= cnt_ff - 6'h01;
          end
        end
        ST_CONV: begin
          cnt_ff <= cnt_ff + 6'h01;
          if (cnt_ff == 6'(CONV_CYCLES - 1)) begin
            cnt_ff <= 6'h00;
            // [RQ21] Partner slot converts second.
            if (simul_ff && !second_ff) begin
              second_ff <= 1'b1;
            end else begin
              second_ff <= 1'b0;
              state_ff <= ST_IDLE;
            end
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      eoc_ff <= '0;
      irq_ff <= '0;
      convVal_ff <= '0;
      convSlot_ff <= 4'h0;
      result_ff <= '0;
    end else if (adcTick) begin
      // [RQ7] One ADC clock wide.
      eoc_ff <= eocSet ? (16'h0001 << tgtSlot) : 16'h0000;
      if (eocSet) begin
        convVal_ff <= outVal;
        convSlot_ff <= tgtSlot;
      end
      // [RQ8] Latch one clock after.
      if (eocAny) begin
        result_ff[convSlot_ff] <= convVal_ff;
      end
      // [RQ9] Interrupt with latch.
      // [RQ13] Only nine interrupts built.
      irq_ff <= irqHit;
    end
  end

  assign apbRsp = rsp_ff;
  assign resultReg = result_ff;
  assign eocOut = eoc_ff;
  // [RQ10] Nine separate outputs.
  assign converterIrqOut = irq_ff;

  eoc_one_adc_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ7]
    $rose(eocAny) |-> eocAny [*2] ##1 !eocAny)
    else $error("End-of-conversion pulse is not one ADC clock long.");

  eoc_at_conv_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ19]
    $rose(eocAny) |-> $past(inConv) && ($past(cnt_ff) == 6'(CONV_CYCLES - 2)))
    else $error("End-of-conversion outside the thirteenth conversion clock.");

  result_latch_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ8]
    (eocAny && adcTick) |=> (result_ff[$past(convSlot_ff)] == $past(convVal_ff)))
    else $error("Result not latched one ADC clock after end-of-conversion.");

  irq_lag_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ9]
    (adcTick && irqHit[0]) |=> irq_ff[0] ##1 irq_ff[0])
    else $error("Interrupt one does not follow its end-of-conversion.");

  irq_disabled_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ11]
    (adcTick && !intSel_ff[0][INT_EN_BIT]) |=> !irq_ff[0])
    else $error("Disabled interrupt fired.");

  irq_bad_src_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ12]
    (adcTick && (irqSrc[2] > SRC_MAX)) |=> !irq_ff[2])
    else $error("Invalid source selection fired an interrupt.");

  single_path_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ3]
    (adcTick && state_ff == ST_SAMP && cnt_ff == 6'h00 && !curSimul) |=> ($stable(heldA_ff) || $stable(heldB_ff)))
    else $error("Both paths active in single mode.");

  ptr_reset_a: assert property (@(posedge clk) // [RQ18]
    $rose(rstn) |-> (ptr_ff == RR_RESET))
    else $error("Pointer not at slot fifteen after reset.");

  retrig_wins_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ16]
    (rtrig_ff[0][9:8] != 2'b00 && !irq1Rise && !irq2Rise) |-> !trigHit[4])
    else $error("Trigger source acted despite a retrigger selection.");
endmodule // adcs_seq_top
`default_nettype wire

//--- tb/adcs_far_model.sv
// Far-side model: PWM trigger sources and the held analog inputs.
// Assumes the bench asks for trigger pulses one clock long, on one or more slots at once.
`timescale 1ns/1ns
`default_nettype none
module adcs_far_model import adcs_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [SLOTS-1:0] fireReq,
  output logic [SLOTS-1:0] pwmTrig,
  output logic [7:0][DW-1:0] chanA,
  output logic [7:0][DW-1:0] chanB
);
  // Inputs stay steady, so the mean of the window equals the level.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      chanA[i] = 12'hA00 + 12'(i);
      chanB[i] = 12'hB00 + 12'(i);
    end
  end

  // Each request becomes a single-clock pulse, one rising edge.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pwmTrig <= '0;
    end else begin
      pwmTrig <= fireReq;
    end
  end
endmodule // adcs_far_model
`default_nettype wire

//--- tb/adcs_seq_top_bench.sv
// Self-checking bench for the sequencer: APB set-up, triggers, results, interrupts.
// Assumes the far-side model in adcs_far_model and the package constants.
`timescale 1ns/1ns
`default_nettype none
module adcs_seq_top_bench import adcs_pkg::*;;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  adcs_apb_req_t req = '0;
  adcs_apb_rsp_t rsp;
  logic [SLOTS-1:0] fireReq = '0;
  logic [SLOTS-1:0] pwmTrig;
  logic [7:0][DW-1:0] chanA;
  logic [7:0][DW-1:0] chanB;
  logic [SLOTS-1:0][DW-1:0] resultReg;
  logic [SLOTS-1:0] eocOut;
  logic [NIRQ-1:0] irqOut;
  logic [SLOTS-1:0] eocSeen = '0;
  logic [NIRQ-1:0] irqSeen = '0;
  logic clrSeen = 1'b0;
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int checksDone = 0;

  always #20 clk = ~clk;

  always @(posedge clk) begin
    eocSeen <= clrSeen ? '0 : (eocSeen | eocOut);
    irqSeen <= clrSeen ? '0 : (irqSeen | irqOut);
  end

  adcs_seq_top i_dut (.clk(clk), .rstn(rstn), .apbReq(req), .apbRsp(rsp), .pwmTrig(pwmTrig),
    .chanA(chanA), .chanB(chanB), .resultReg(resultReg), .eocOut(eocOut), .converterIrqOut(irqOut));

  adcs_far_model i_far (.clk(clk), .rstn(rstn), .fireReq(fireReq), .pwmTrig(pwmTrig),
    .chanA(chanA), .chanB(chanB));

  task automatic finish_test;
    $display("checks %0d errors %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic checkVal(input string name, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic timeout(input string name);
    errors++;
    $display("mismatch %s expected answer seen timeout", name);
    finish_test();
  endtask

  task automatic apbXfer(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) begin
      timeout("pready");
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [15:0] d);
    apbXfer(1'b1, a, {16'h0000, d});
  endtask

  task automatic rdChk(input logic [AW-1:0] a, input logic [31:0] exp, input logic [31:0] mask, input string name);
    apbXfer(1'b0, a, 32'h0000_0000);
    checkVal(name, exp, rd & mask);
  endtask

  task automatic fire(input logic [SLOTS-1:0] mask);
    @(posedge clk);
    fireReq <= mask;
    clrSeen <= 1'b0;
    @(posedge clk);
    fireReq <= '0;
  endtask

  task automatic clearSeen;
    @(posedge clk);
    clrSeen <= 1'b1;
  endtask

  task automatic waitEoc(input int slot, input logic [DW-1:0] res, input logic [NIRQ-1:0] irq);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (eocOut === '0 && n < 300);
    if (eocOut === '0) begin
      timeout("eoc");
    end
    checkVal("eoc one-hot", 32'(1 << slot), 32'(eocOut));
    checkVal("irq before eoc", 32'h0000_0000, 32'(irqOut));
    @(posedge clk);
    #1;
    checkVal("eoc held", 32'(1 << slot), 32'(eocOut));
    @(posedge clk);
    #1;
    checkVal("eoc ended", 32'h0000_0000, 32'(eocOut));
    checkVal("result", 32'(res), 32'(resultReg[slot]));
    checkVal("irq", 32'(irq), 32'(irqOut));
    @(posedge clk);
    #1;
    checkVal("irq held", 32'(irq), 32'(irqOut));
    @(posedge clk);
    #1;
    checkVal("irq ended", 32'h0000_0000, 32'(irqOut));
  endtask

  function automatic logic [15:0] cfg(input logic [4:0] t, input logic [3:0] c, input logic [5:0] a);
    return {t, 1'b0, c, a};
  endfunction

  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rdChk(OFS_STATUS, 32'h000F_0000, 32'h000F_0000, "pointer");
    rdChk(8'h80, 32'h0000_0000, 32'hFFFF_FFFF, "unmapped data");
    checkVal("unmapped error", 32'h0000_0001, 32'(err));
    rdChk(OFS_MODE, 32'h0000_0000, 32'hFFFF_FFFF, "mode reset");
    wr(OFS_MODE, 16'h0001);
    rdChk(OFS_MODE, 32'h0000_0001, 32'hFFFF_FFFF, "mode");
    wr(OFS_SLOT0, cfg(5'h05, 4'h2, 6'h06));
    wr(OFS_SLOT0 + 8'h04, cfg(5'h00, 4'h5, 6'h07));
    wr(OFS_SLOT0 + 8'h10, cfg(5'h07, 4'h1, 6'h06));
    wr(OFS_SLOT0 + 8'h14, cfg(5'h06, 4'hB, 6'h06));
    rdChk(OFS_SLOT0 + 8'h14, 32'(cfg(5'h06, 4'hB, 6'h06)), 32'hFFFF_FFFF, "slot cfg");
    // Continuous bit set on every used interrupt, late pulses only.
    wr(OFS_INTSEL0, 16'h4560);
    wr(OFS_INTSEL0 + 8'h04, 16'h6170);
    wr(OFS_INTSEL0 + 8'h10, 16'h6040);
    wr(OFS_RTRIG_LO, 16'h0100);
    clearSeen();
    fire(16'h0001);
    waitEoc(0, 12'hA02, 9'h001);
    waitEoc(1, 12'hB02, 9'h008);
    waitEoc(4, 12'hA01, 9'h000);
    checkVal("irq seen", 32'h0000_0009, 32'(irqSeen));
    clearSeen();
    fire(16'h0004);
    repeat (150) @(posedge clk);
    checkVal("overridden trigger", 32'h0000_0000, 32'(eocSeen));
    wr(OFS_MODE, 16'h0000);
    rdChk(OFS_STATUS, 32'h0004_0000, 32'h000F_0000, "pointer after run");
    // Slot eight follows interrupt two; slot nine holds the invalid retrigger code.
    wr(OFS_RTRIG_HI, 16'h000E);
    wr(OFS_SLOT0 + 8'h24, cfg(5'h06, 4'h0, 6'h06));
    wr(OFS_INTSEL0, 16'h6560);
    clearSeen();
    fire(16'h0003);
    waitEoc(5, 12'hB03, 9'h002);
    waitEoc(8, 12'hA00, 9'h000);
    waitEoc(0, 12'hA02, 9'h001);
    waitEoc(4, 12'hA01, 9'h000);
    repeat (100) @(posedge clk);
    checkVal("eoc seen", 32'h0000_0131, 32'(eocSeen));
    finish_test();
  end
endmodule // adcs_seq_top_bench
`default_nettype wire
